// >>> design/ucm_pkg.sv
// constants and types shared by the usb clock and fail-safe monitor block
package ucm_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'h04;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h08;
  localparam logic [7:0] ADDR_IRQ_PRI = 8'h0C;
  localparam logic [7:0] ADDR_CFG_ONE = 8'h10;
  // field positions
  localparam int OSC_SWREQ_BIT = 0;
  localparam int OSC_URC_BIT = 2;
  localparam int OSC_CF_BIT = 3;
  localparam int OSC_LOCK_BIT = 6;
  localparam int OSC_NEXT_OSCILLATOR_LSB = 8;
  localparam int OSC_CURRENT_OSCILLATOR_LSB = 12;
  localparam int IRQ_FAIL_BIT = 14;
  localparam int PRI_LSB = 10;
  localparam int SUB_LSB = 8;
  localparam int CFG_MON_LSB = 14;
  localparam int CFG_DEF_LSB = 0;
  // oscillator selection codes
  localparam logic [2:0] OSC_FRC = 3'h0;
  localparam logic [2:0] OSC_PRIMARY_OSCILLATOR = 3'h2;
  localparam logic [2:0] OSC_PRIMARY_OSCILLATOR_PLL = 3'h3;
  // usb clock source codes
  localparam logic [1:0] USB_SRC_FRC = 2'h0;
  localparam logic [1:0] USB_SRC_PRIMARY_OSCILLATOR = 2'h1;
  localparam logic [1:0] USB_SRC_PLL = 2'h2;
  // clock monitor config decode
  localparam logic [1:0] MON_SW_AND_FAILSAFE_CLOCK_MONITOR = 2'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing, in ns, and derived counts
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOW_POWER_RC_PERIOD_NS = 32000;
  localparam int TICK_CYCLES = LOW_POWER_RC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int USB_PLL_LOCKED_NS = 2000;
  localparam int MONITOR_START_DELAY_NS = 2000000;
  localparam int FAIL_WINDOW_NS = 64000;
  localparam logic [7:0] USB_PLL_LOCKED_CYCLES =
    8'((USB_PLL_LOCKED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] MONITOR_START_DELAY_TICKS =
    8'((MONITOR_START_DELAY_NS + LOW_POWER_RC_PERIOD_NS - 1) / LOW_POWER_RC_PERIOD_NS);
  localparam logic [7:0] FAIL_WINDOW_TICKS =
    8'(FAIL_WINDOW_NS / LOW_POWER_RC_PERIOD_NS);
  localparam logic [7:0] PRIMARY_OSCILLATOR_STABLE_EDGES = 8'h40;
  // monitor states
  typedef enum logic [3:0] {
    ST_START = 4'h1,
    ST_MONITOR = 4'h2,
    ST_RUN = 4'h4,
    ST_FAILED = 4'h8
  } ucm_state_t;
endpackage : ucm_pkg

// >>> design/ucm_pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulse
`timescale 1ns/1ps
module ucm_pin_sync (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // pin and result
  input wire logic i_pin,
  output logic o_level,
  output logic o_edge
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic edg;
  } ucm_sync_t;
  ucm_sync_t s_r;
  ucm_sync_t s_nxt;

  // s1 is read only by s2; the filter looks at s2 and s3
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = i_pin;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    s_nxt.edg = 1'b0;
    if (s_r.s2 == s_r.s3 && s_r.s3 != s_r.lvl) begin
      s_nxt.lvl = s_r.s3;
      s_nxt.edg = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_level = s_r.lvl;
  assign o_edge = s_r.edg;
endmodule : ucm_pin_sync

// >>> design/ucm_tick_div.sv
// divider making the low-power rc timebase tick from the system clock
`timescale 1ns/1ps
module ucm_tick_div #(
  parameter int DIV = 3200
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // one-cycle tick
  output logic o_tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } ucm_div_t;
  ucm_div_t d_r;
  ucm_div_t d_nxt;

  // free-running count, tick on wrap
  always_comb begin
    d_nxt = d_r;
    d_nxt.tick = 1'b0;
    if (d_r.cnt == 16'(DIV - 1)) begin
      d_nxt.cnt = 16'h0000;
      d_nxt.tick = 1'b1;
    end else begin
      d_nxt.cnt = d_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      d_r <= '0;
    end else begin
      d_r <= d_nxt;
    end
  end

  assign o_tick = d_r.tick;
endmodule : ucm_tick_div

// >>> design/ucm_top.sv
// usb clock select, two-speed start-up and fail-safe clock monitor
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module ucm_top
  import ucm_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // axi4-lite write address and data
  input wire logic [7:0] i_axi_awaddr,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  // axi4-lite write response
  output logic [1:0] o_axi_bresp,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  // axi4-lite read
  input wire logic [7:0] i_axi_araddr,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  // configuration fuses, sampled at reset
  input wire logic [1:0] i_clock_monitor_config,
  input wire logic [2:0] i_default_oscillator_select,
  input wire logic i_usb_pll_enable,
  // events and pins
  input wire logic i_sleep_wake,
  input wire logic i_usb_suspend,
  input wire logic i_primary_oscillator,
  // clock control outputs
  output logic [2:0] o_system_clock_sel,
  output logic [1:0] o_usb_module_clock_src,
  output logic o_usb_pll_half,
  output logic o_primary_oscillator_en,
  output logic o_low_power_rc_tick,
  // interrupt request
  output logic o_osc_fail_irq,
  output logic [2:0] o_osc_fail_irq_priority,
  output logic [1:0] o_osc_fail_irq_subpriority
);
  typedef struct packed {
    ucm_state_t st;
    logic [2:0] current_oscillator;
    logic [2:0] next_oscillator;
    logic swreq;
    logic urc;
    logic cf;
    logic lock;
    logic iflag;
    logic ien;
    logic [2:0] pri;
    logic [1:0] sub;
    logic [1:0] cfg_mon;
    logic [2:0] cfg_def;
    logic cfg_usb_pll;
    logic [7:0] tcnt;
    logic [7:0] ecnt;
    logic [7:0] lcnt;
    logic [1:0] usb_src;
    logic pll_half;
    logic primary_oscillator_en;
    logic irq;
    logic awrdy;
    logic aw_hold;
    logic [7:0] awaddr;
    logic wrdy;
    logic w_hold;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ucm_regs_t;
  ucm_regs_t s_r;
  ucm_regs_t s_nxt;
  ucm_regs_t s_rst;

  logic tick;
  logic primary_oscillator_edge;

  // expand byte strobes to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : strb_mask

  // primary oscillator codes, with or without pll
  function automatic logic is_primary_oscillator(input logic [2:0] code);
    return (code == OSC_PRIMARY_OSCILLATOR) || (code == OSC_PRIMARY_OSCILLATOR_PLL);
  endfunction : is_primary_oscillator

  // low-power rc timebase, independent of the selected system clock
  ucm_tick_div #(
    .DIV(TICK_DIV)
  ) u_tick (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .o_tick(tick)
  );

  // primary oscillator activity enters through the pin filter
  ucm_pin_sync u_primary_oscillator (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_pin(i_primary_oscillator),
    .o_level(),
    .o_edge(primary_oscillator_edge)
  );

  // power-on value; fuses are caught here and not changed later
  always_comb begin
    s_rst = '0;
    s_rst.cfg_mon = i_clock_monitor_config;
    s_rst.cfg_def = i_default_oscillator_select;
    s_rst.cfg_usb_pll = i_usb_pll_enable;
    s_rst.next_oscillator = i_default_oscillator_select;
    s_rst.primary_oscillator_en = 1'b1;
    s_rst.usb_src = USB_SRC_FRC;
    // two-speed only while switching is enabled
    if (!i_clock_monitor_config[1] &&
        is_primary_oscillator(i_default_oscillator_select)) begin
      s_rst.st = ST_START;
      s_rst.current_oscillator = OSC_FRC;
    end else begin
      s_rst.st = ST_RUN;
      s_rst.current_oscillator = i_default_oscillator_select;
    end
  end

  // next-state logic: bus first, hardware after so its sets win
  always_comb begin
    logic [31:0] wm;
    logic [31:0] wv;
    logic fail;
    wm = strb_mask(s_r.wstrb);
    wv = s_r.wdata;
    fail = 1'b0;
    s_nxt = s_r;

    // axi address and data captured in either order
    if (i_axi_awvalid && s_r.awrdy) begin
      s_nxt.aw_hold = 1'b1;
      s_nxt.awaddr = i_axi_awaddr;
    end
    if (i_axi_wvalid && s_r.wrdy) begin
      s_nxt.w_hold = 1'b1;
      s_nxt.wdata = i_axi_wdata;
      s_nxt.wstrb = i_axi_wstrb;
    end
    if (s_r.bvalid && i_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // commit once both halves are held
    if (s_r.aw_hold && s_r.w_hold && !s_r.bvalid) begin
      s_nxt.aw_hold = 1'b0;
      s_nxt.w_hold = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      case (s_r.awaddr)
        ADDR_OSC_CTRL: begin
          if (wm[OSC_URC_BIT]) begin
            s_nxt.urc = wv[OSC_URC_BIT];
          end
          if (wm[OSC_CF_BIT]) begin
            s_nxt.cf = wv[OSC_CF_BIT];
          end
          if (wm[OSC_NEXT_OSCILLATOR_LSB]) begin
            s_nxt.next_oscillator = wv[OSC_NEXT_OSCILLATOR_LSB +: 3];
          end
          // request held low while switching is disabled
          if (wm[OSC_SWREQ_BIT] && !s_r.cfg_mon[1]) begin
            s_nxt.swreq = wv[OSC_SWREQ_BIT];
          end
        end
        ADDR_IRQ_FLAG: begin
          if (wm[IRQ_FAIL_BIT]) begin
            s_nxt.iflag = wv[IRQ_FAIL_BIT];
          end
        end
        ADDR_IRQ_EN: begin
          if (wm[IRQ_FAIL_BIT]) begin
            s_nxt.ien = wv[IRQ_FAIL_BIT];
          end
        end
        ADDR_IRQ_PRI: begin
          if (wm[PRI_LSB]) begin
            s_nxt.pri = wv[PRI_LSB +: 3];
          end
          if (wm[SUB_LSB]) begin
            s_nxt.sub = wv[SUB_LSB +: 2];
          end
        end
        ADDR_CFG_ONE: begin
          s_nxt.bresp = RESP_OKAY; // read-only, write ignored
        end
        default: begin
          s_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end

    // read path, one word per request
    if (s_r.rvalid && i_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (i_axi_arvalid && s_r.arrdy) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      s_nxt.rdata = 32'h0000_0000;
      case (i_axi_araddr)
        ADDR_OSC_CTRL: begin
          s_nxt.rdata[OSC_SWREQ_BIT] = s_r.swreq;
          s_nxt.rdata[OSC_URC_BIT] = s_r.urc;
          s_nxt.rdata[OSC_CF_BIT] = s_r.cf;
          s_nxt.rdata[OSC_LOCK_BIT] = s_r.lock;
          s_nxt.rdata[OSC_NEXT_OSCILLATOR_LSB +: 3] = s_r.next_oscillator;
          s_nxt.rdata[OSC_CURRENT_OSCILLATOR_LSB +: 3] = s_r.current_oscillator;
        end
        ADDR_IRQ_FLAG: s_nxt.rdata[IRQ_FAIL_BIT] = s_r.iflag;
        ADDR_IRQ_EN: s_nxt.rdata[IRQ_FAIL_BIT] = s_r.ien;
        ADDR_IRQ_PRI: begin
          s_nxt.rdata[PRI_LSB +: 3] = s_r.pri;
          s_nxt.rdata[SUB_LSB +: 2] = s_r.sub;
        end
        ADDR_CFG_ONE: begin
          s_nxt.rdata[CFG_MON_LSB +: 2] = s_r.cfg_mon;
          s_nxt.rdata[CFG_DEF_LSB +: 3] = s_r.cfg_def;
        end
        default: s_nxt.rresp = RESP_SLVERR;
      endcase
    end

    // monitor sequence
    case (s_r.st)
      ST_START: begin
        s_nxt.current_oscillator = OSC_FRC;
        if (tick) begin
          s_nxt.tcnt = s_r.tcnt + 8'h01;
        end
        if (primary_oscillator_edge) begin
          s_nxt.ecnt = s_r.ecnt + 8'h01;
        end
        if (s_r.ecnt >= PRIMARY_OSCILLATOR_STABLE_EDGES) begin
          s_nxt.current_oscillator = s_r.next_oscillator;
          s_nxt.swreq = 1'b0;
          s_nxt.tcnt = 8'h00;
          s_nxt.st = (s_r.cfg_mon == MON_SW_AND_FAILSAFE_CLOCK_MONITOR) ?
                     ST_MONITOR : ST_RUN;
        end else if (s_r.cfg_mon == MON_SW_AND_FAILSAFE_CLOCK_MONITOR &&
                     s_r.tcnt >= MONITOR_START_DELAY_TICKS) begin
          fail = 1'b1;
        end
      end
      ST_MONITOR: begin
        // window restarts on every edge of the watched clock
        if (primary_oscillator_edge) begin
          s_nxt.tcnt = 8'h00;
        end else if (tick) begin
          s_nxt.tcnt = s_r.tcnt + 8'h01;
        end
        if (s_r.tcnt >= FAIL_WINDOW_TICKS) begin
          fail = 1'b1;
        end
      end
      ST_RUN, ST_FAILED: begin
        // software switch is the only way out of failure
        if (s_r.swreq) begin
          s_nxt.tcnt = 8'h00;
          s_nxt.ecnt = 8'h00;
          if (s_r.next_oscillator == s_r.current_oscillator) begin
            s_nxt.swreq = 1'b0;
          end else if (is_primary_oscillator(s_r.next_oscillator)) begin
            s_nxt.st = ST_START;
            s_nxt.current_oscillator = OSC_FRC;
            s_nxt.primary_oscillator_en = 1'b1;
          end else begin
            s_nxt.st = ST_RUN;
            s_nxt.current_oscillator = s_r.next_oscillator;
            s_nxt.swreq = 1'b0;
          end
        end
      end
      default: s_nxt.st = ST_RUN;
    endcase

    // wake from sleep restarts the start-up timing
    if (i_sleep_wake && s_r.st != ST_FAILED &&
        !s_r.cfg_mon[1] && is_primary_oscillator(s_r.cfg_def)) begin
      s_nxt.st = ST_START;
      s_nxt.current_oscillator = OSC_FRC;
      s_nxt.next_oscillator = s_r.cfg_def;
      s_nxt.tcnt = 8'h00;
      s_nxt.ecnt = 8'h00;
      s_nxt.primary_oscillator_en = 1'b1;
    end

    // fail-over does not look at the irq enable
    if (fail) begin
      s_nxt.st = ST_FAILED;
      s_nxt.current_oscillator = OSC_FRC;
      s_nxt.cf = 1'b1;
      s_nxt.swreq = 1'b0;
      s_nxt.iflag = 1'b1;
      s_nxt.primary_oscillator_en = 1'b0;
    end

    // usb source: rc only while suspended with wake enabled
    if (i_usb_suspend && s_r.urc) begin
      s_nxt.usb_src = USB_SRC_FRC;
    end else if (s_r.cfg_usb_pll) begin
      s_nxt.usb_src = USB_SRC_PLL;
    end else begin
      s_nxt.usb_src = USB_SRC_PRIMARY_OSCILLATOR;
    end
    s_nxt.pll_half = (s_nxt.usb_src == USB_SRC_PLL);

    // lock is a nominal delay, not a real lock detector
    if (s_nxt.usb_src != USB_SRC_PLL) begin
      s_nxt.lock = 1'b0;
      s_nxt.lcnt = 8'h00;
    end else if (s_r.lcnt >= USB_PLL_LOCKED_CYCLES) begin
      s_nxt.lock = 1'b1;
    end else begin
      s_nxt.lcnt = s_r.lcnt + 8'h01;
    end

    // registered handshakes and irq
    s_nxt.irq = s_nxt.iflag & s_nxt.ien;
    s_nxt.awrdy = !s_nxt.aw_hold && !s_nxt.bvalid;
    s_nxt.wrdy = !s_nxt.w_hold && !s_nxt.bvalid;
    s_nxt.arrdy = !s_nxt.rvalid;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_r <= s_rst;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs, all from the state register except the rc tick, which comes from the divider
  assign o_axi_awready = s_r.awrdy;
  assign o_axi_wready = s_r.wrdy;
  assign o_axi_bresp = s_r.bresp;
  assign o_axi_bvalid = s_r.bvalid;
  assign o_axi_arready = s_r.arrdy;
  assign o_axi_rdata = s_r.rdata;
  assign o_axi_rresp = s_r.rresp;
  assign o_axi_rvalid = s_r.rvalid;
  assign o_system_clock_sel = s_r.current_oscillator;
  assign o_usb_module_clock_src = s_r.usb_src;
  assign o_usb_pll_half = s_r.pll_half;
  assign o_primary_oscillator_en = s_r.primary_oscillator_en;
  assign o_low_power_rc_tick = tick;
  assign o_osc_fail_irq = s_r.irq;
  assign o_osc_fail_irq_priority = s_r.pri;
  assign o_osc_fail_irq_subpriority = s_r.sub;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  chk_fail_loads_rc: assert property (
    $rose(s_r.cf) && s_r.st == ST_FAILED |-> s_r.current_oscillator == OSC_FRC
      && !s_r.swreq && s_r.iflag)
    else $error("fail-over did not load rc or clear request");
  chk_fail_stays: assert property (
    s_r.st == ST_FAILED && !s_r.swreq |=> s_r.current_oscillator == OSC_FRC)
    else $error("failed state left rc without switch");
  chk_start_on_rc: assert property (
    s_r.st == ST_START |-> o_system_clock_sel == OSC_FRC)
    else $error("start-up not on rc");
  chk_window_bound: assert property (
    s_r.st == ST_MONITOR |-> s_r.tcnt <= FAIL_WINDOW_TICKS)
    else $error("window count past limit");
  chk_failover_any_en: assert property (
    s_r.st == ST_MONITOR && s_r.tcnt >= FAIL_WINDOW_TICKS |=>
      s_r.st == ST_FAILED && s_r.current_oscillator == OSC_FRC && !s_r.primary_oscillator_en)
    else $error("expired window did not fail over");
  chk_irq_gated: assert property (
    s_r.iflag && !s_r.ien && !$past(s_r.ien) |-> !o_osc_fail_irq)
    else $error("irq raised while disabled");
  chk_lock_no_pll: assert property (
    s_r.usb_src != USB_SRC_PLL |-> !s_r.lock)
    else $error("lock set without pll");
  chk_usb_suspend_rc: assert property (
    i_usb_suspend && s_r.urc |=> o_usb_module_clock_src == USB_SRC_FRC)
    else $error("suspend wake source not rc");
  chk_pll_halved: assert property (
    o_usb_module_clock_src == USB_SRC_PLL |-> o_usb_pll_half)
    else $error("pll source without divide by two");
  chk_switch_disabled: assert property (
    s_r.cfg_mon[1] |-> !s_r.swreq && s_r.current_oscillator == s_r.cfg_def)
    else $error("switching active while disabled");
  chk_bresp_after_both: assert property (
    $rose(o_axi_bvalid) |-> $past(s_r.aw_hold && s_r.w_hold))
    else $error("write answered before both halves");

  cov_failover: cover property (s_r.st == ST_MONITOR ##1
    s_r.st == ST_FAILED);
  cov_twospeed_done: cover property (s_r.st == ST_START ##1
    s_r.st == ST_MONITOR);
  cov_lock_set: cover property ($rose(s_r.lock));
endmodule : ucm_top

// >>> verification/ucm_top_test.sv
// self-checking bench for the usb clock and fail-safe monitor block
`timescale 1ns/1ps
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); \
  end \
end
`define WAITC(c, lim) begin \
  wn = 0; \
  while (!(c) && wn < (lim)) begin \
    @(posedge i_clk); \
    wn++; \
  end \
end
module ucm_top_test;
  import ucm_pkg::*;
  // short rc tick keeps start-up and fail windows brief
  localparam int TDIV = 16;
  logic i_clk, i_srst, i_axi_awvalid, i_axi_wvalid, i_axi_bready;
  logic i_axi_arvalid, i_axi_rready, i_usb_pll_enable, i_sleep_wake;
  logic i_usb_suspend, i_primary_oscillator, osc_run;
  logic o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready;
  logic o_axi_rvalid, o_usb_pll_half, o_primary_oscillator_en;
  logic o_low_power_rc_tick, o_osc_fail_irq;
  logic [7:0] i_axi_awaddr, i_axi_araddr;
  logic [31:0] i_axi_wdata, o_axi_rdata, d;
  logic [1:0] o_axi_bresp, o_axi_rresp, r, i_clock_monitor_config;
  logic [1:0] o_usb_module_clock_src, o_osc_fail_irq_subpriority;
  logic [2:0] i_default_oscillator_select, o_system_clock_sel;
  logic [2:0] o_osc_fail_irq_priority;
  logic [1:0] ph;
  int n_errors = 0;
  int samples_checked = 0;
  int wn, nt;

  ucm_top #(.TICK_DIV(TDIV)) DUT (
    .i_clk(i_clk), .i_srst(i_srst),
    .i_axi_awaddr(i_axi_awaddr), .i_axi_awvalid(i_axi_awvalid),
    .o_axi_awready(o_axi_awready), .i_axi_wdata(i_axi_wdata),
    .i_axi_wstrb(4'hF), .i_axi_wvalid(i_axi_wvalid),
    .o_axi_wready(o_axi_wready), .o_axi_bresp(o_axi_bresp),
    .o_axi_bvalid(o_axi_bvalid), .i_axi_bready(i_axi_bready),
    .i_axi_araddr(i_axi_araddr), .i_axi_arvalid(i_axi_arvalid),
    .o_axi_arready(o_axi_arready), .o_axi_rdata(o_axi_rdata),
    .o_axi_rresp(o_axi_rresp), .o_axi_rvalid(o_axi_rvalid),
    .i_axi_rready(i_axi_rready),
    .i_clock_monitor_config(i_clock_monitor_config),
    .i_default_oscillator_select(i_default_oscillator_select),
    .i_usb_pll_enable(i_usb_pll_enable), .i_sleep_wake(i_sleep_wake),
    .i_usb_suspend(i_usb_suspend),
    .i_primary_oscillator(i_primary_oscillator),
    .o_system_clock_sel(o_system_clock_sel),
    .o_usb_module_clock_src(o_usb_module_clock_src),
    .o_usb_pll_half(o_usb_pll_half),
    .o_primary_oscillator_en(o_primary_oscillator_en),
    .o_low_power_rc_tick(o_low_power_rc_tick),
    .o_osc_fail_irq(o_osc_fail_irq),
    .o_osc_fail_irq_priority(o_osc_fail_irq_priority),
    .o_osc_fail_irq_subpriority(o_osc_fail_irq_subpriority)
  );

  // 100 MHz clock
  initial begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end

  // primary oscillator pin: slow toggle so the sync filter always agrees
  always @(posedge i_clk) begin
    ph <= ph + 2'h1;
    if (osc_run && ph == 2'h3) begin
      i_primary_oscillator <= ~i_primary_oscillator;
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // fuses are only sampled while reset is high
  task automatic do_reset(input logic [1:0] c, input logic [2:0] o,
                          input logic p);
    @(posedge i_clk);
    i_clock_monitor_config <= c;
    i_default_oscillator_select <= o;
    i_usb_pll_enable <= p;
    i_srst <= 1'h1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'h0;
  endtask : do_reset

  // aw and w offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    int n;
    @(posedge i_clk);
    i_axi_awaddr <= a;
    i_axi_wdata <= v;
    i_axi_awvalid <= 1'h1;
    i_axi_wvalid <= 1'h1;
    i_axi_bready <= 1'h1;
    rs = 2'h3;
    for (n = 0; n < 200; n++) begin
      @(posedge i_clk);
      if (i_axi_awvalid && o_axi_awready)
        i_axi_awvalid <= 1'h0;
      if (i_axi_wvalid && o_axi_wready)
        i_axi_wvalid <= 1'h0;
      if (o_axi_bvalid) begin
        rs = o_axi_bresp;
        i_axi_bready <= 1'h0;
        break;
      end
    end
    if (n >= 200) begin
      n_errors++;
      $display("ERROR %0t: write not answered", $time);
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    int n;
    @(posedge i_clk);
    i_axi_araddr <= a;
    i_axi_arvalid <= 1'h1;
    i_axi_rready <= 1'h1;
    v = 32'h0;
    rs = 2'h3;
    for (n = 0; n < 200; n++) begin
      @(posedge i_clk);
      if (i_axi_arvalid && o_axi_arready)
        i_axi_arvalid <= 1'h0;
      if (o_axi_rvalid) begin
        v = o_axi_rdata;
        rs = o_axi_rresp;
        i_axi_rready <= 1'h0;
        break;
      end
    end
    if (n >= 200) begin
      n_errors++;
      $display("ERROR %0t: read not answered", $time);
    end
  endtask : rd

  // hang guard, far above the expected run of some 3.3k cycles
  initial begin
    #300000;
    n_errors++;
    $display("ERROR %0t: run timed out", $time);
    give_verdict();
  end

  // main sequence
  initial begin
    // reset from time zero keeps unknown fuses out of the state
    i_srst = 1'h1;
    {i_axi_awvalid, i_axi_wvalid, i_axi_bready} = '0;
    {i_axi_arvalid, i_axi_rready, i_sleep_wake, i_usb_suspend} = '0;
    {i_primary_oscillator, osc_run, ph} = '0;
    i_axi_awaddr = 8'h0;
    i_axi_araddr = 8'h0;
    i_axi_wdata = 32'h0;
    do_reset(2'h0, OSC_PRIMARY_OSCILLATOR, 1'h0);
    // two-speed start: rc first, then primary once it runs
    `CHK(o_system_clock_sel, OSC_FRC)
    rd(ADDR_OSC_CTRL, d, r);
    `CHK(d, 32'h0000_0200)
    rd(ADDR_CFG_ONE, d, r);
    `CHK(d, 32'h0000_0002)
    `CHK(o_usb_module_clock_src, USB_SRC_PRIMARY_OSCILLATOR)
    `CHK(o_usb_pll_half, 1'h0)
    rd(8'hFC, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
    wr(ADDR_CFG_ONE, 32'hFFFF_FFFF, r);
    `CHK(r, RESP_OKAY)
    rd(ADDR_CFG_ONE, d, r);
    `CHK(d, 32'h0000_0002)
    osc_run <= 1'h1;
    `WAITC(o_system_clock_sel === OSC_PRIMARY_OSCILLATOR, 1200)
    `CHK(o_system_clock_sel, OSC_PRIMARY_OSCILLATOR)
    rd(ADDR_OSC_CTRL, d, r);
    `CHK(d[14:12], OSC_PRIMARY_OSCILLATOR)
    // wake from sleep restarts the two-speed sequence
    @(posedge i_clk);
    i_sleep_wake <= 1'h1;
    @(posedge i_clk);
    i_sleep_wake <= 1'h0;
    `WAITC(o_system_clock_sel === OSC_FRC, 40)
    `CHK(o_system_clock_sel, OSC_FRC)
    `WAITC(o_system_clock_sel === OSC_PRIMARY_OSCILLATOR, 1200)
    `CHK(o_system_clock_sel, OSC_PRIMARY_OSCILLATOR)
    // interrupt set up with enable still off, then primary dies
    wr(ADDR_IRQ_FLAG, 32'h0, r);
    wr(ADDR_IRQ_PRI, 32'h0000_1600, r);
    `CHK({o_osc_fail_irq_priority, o_osc_fail_irq_subpriority}, 5'h16)
    osc_run <= 1'h0;
    `WAITC(o_primary_oscillator_en === 1'h0, 200)
    `CHK(o_primary_oscillator_en, 1'h0)
    `CHK(o_system_clock_sel, OSC_FRC)
    rd(ADDR_OSC_CTRL, d, r);
    `CHK({d[14:12], d[OSC_CF_BIT], d[OSC_SWREQ_BIT]}, 5'h2)
    rd(ADDR_IRQ_FLAG, d, r);
    `CHK(d[IRQ_FAIL_BIT], 1'h1)
    `CHK(o_osc_fail_irq, 1'h0)
    wr(ADDR_IRQ_EN, 32'h0000_4000, r);
    repeat (2) @(posedge i_clk);
    `CHK(o_osc_fail_irq, 1'h1)
    // returning oscillator must not undo the fail-over by itself
    osc_run <= 1'h1;
    repeat (300) @(posedge i_clk);
    `CHK(o_system_clock_sel, OSC_FRC)
    nt = 0;
    repeat (10 * TDIV) begin
      @(posedge i_clk);
      nt += int'(o_low_power_rc_tick === 1'h1);
    end
    `CHK(nt, 10)
    wr(ADDR_IRQ_FLAG, 32'h0, r);
    repeat (2) @(posedge i_clk);
    `CHK(o_osc_fail_irq, 1'h0)
    // software switch back to primary is the way out of failure
    wr(ADDR_OSC_CTRL, 32'h0000_0201, r);
    `WAITC(o_system_clock_sel === OSC_PRIMARY_OSCILLATOR, 1200)
    rd(ADDR_OSC_CTRL, d, r);
    `CHK({d[14:12], d[OSC_SWREQ_BIT]}, 4'h4)
    // primary never starts: delay first, then failure
    osc_run <= 1'h0;
    do_reset(2'h0, OSC_PRIMARY_OSCILLATOR, 1'h0);
    repeat (500) @(posedge i_clk);
    rd(ADDR_OSC_CTRL, d, r);
    `CHK(d[OSC_CF_BIT], 1'h0)
    `WAITC(o_primary_oscillator_en === 1'h0, 1000)
    `CHK(o_primary_oscillator_en, 1'h0)
    rd(ADDR_IRQ_FLAG, d, r);
    `CHK(d[IRQ_FAIL_BIT], 1'h1)
    // switching only: a dead primary goes unnoticed
    osc_run <= 1'h1;
    do_reset(2'h1, OSC_PRIMARY_OSCILLATOR, 1'h0);
    `WAITC(o_system_clock_sel === OSC_PRIMARY_OSCILLATOR, 1200)
    osc_run <= 1'h0;
    repeat (400) @(posedge i_clk);
    `CHK({o_system_clock_sel, o_primary_oscillator_en}, 4'h5)
    // both features off: straight to the default oscillator, pll usb
    do_reset(2'h2, OSC_PRIMARY_OSCILLATOR_PLL, 1'h1);
    `CHK(o_system_clock_sel, OSC_PRIMARY_OSCILLATOR_PLL)
    // usb source leaves its reset value one edge after release
    repeat (2) @(posedge i_clk);
    `CHK({o_usb_module_clock_src, o_usb_pll_half}, {USB_SRC_PLL, 1'h1})
    repeat (100) @(posedge i_clk);
    rd(ADDR_OSC_CTRL, d, r);
    `CHK(d[OSC_LOCK_BIT], 1'h0)
    repeat (150) @(posedge i_clk);
    rd(ADDR_OSC_CTRL, d, r);
    `CHK(d[OSC_LOCK_BIT], 1'h1)
    wr(ADDR_OSC_CTRL, 32'h0000_0044, r);
    rd(ADDR_OSC_CTRL, d, r);
    `CHK({d[OSC_URC_BIT], d[OSC_LOCK_BIT]}, 2'h3)
    i_usb_suspend <= 1'h1;
    repeat (3) @(posedge i_clk);
    `CHK(o_usb_module_clock_src, USB_SRC_FRC)
    rd(ADDR_OSC_CTRL, d, r);
    `CHK(d[OSC_LOCK_BIT], 1'h0)
    i_usb_suspend <= 1'h0;
    repeat (3) @(posedge i_clk);
    `CHK(o_usb_module_clock_src, USB_SRC_PLL)
    give_verdict();
  end
endmodule : ucm_top_test
